// File: common/power_fail_defines.vh
`ifndef POWER_FAIL_DEFINES_VH
`define POWER_FAIL_DEFINES_VH

// byte offsets of the register map
`define OFF_POWERFAIL_CONFIG 12'h0510
`define OFF_SCRATCH_A 12'h051C
`define OFF_SCRATCH_B 12'h0520
`define OFF_BUCK_ENABLE 12'h0578
`define OFF_MAIN_SUPPLY 12'h0640
`define OFF_IRQ_STATUS 12'h0700
`define OFF_IRQ_MASK 12'h0704

// powerfail_config field positions
`define WARN_ENABLE_BIT 0
`define FAIL_LEVEL_LSB 1
`define FAIL_LEVEL_MSB 4
`define HIGH_LEVEL_LSB 8
`define HIGH_LEVEL_MSB 11
`define POWERFAIL_CONFIG_MASK 32'h0000_0F1F

// reset values
`define RESET_POWERFAIL_CONFIG 32'h0000_0000
`define RESET_SCRATCH 32'h0000_0000
`define RESET_BUCK_ENABLE 32'h0000_0000

// threshold codes in tenths of a volt
`define FAIL_LEVEL_BASE_CODE 4'h4
`define FAIL_LEVEL_BASE_DV 8'h11
`define HIGH_LEVEL_BASE_DV 8'h1B

`endif

// File: hdl/threshold_select.v
`timescale 1ns/1ps
`default_nettype none
`include "power_fail_defines.vh"

module threshold_select
(
    // configuration
    input wire [3:0] fail_level,
    input wire [3:0] high_rail_fail_level,
    input wire high_voltage_mode,
    // selected threshold, tenths of a volt
    output reg [7:0] threshold_dv,
    output reg level_legal
);
    always @*
    begin
        if (high_voltage_mode)
        begin
            // high rail code 0 is 2.7 V, 0.1 V per step
            threshold_dv = `HIGH_LEVEL_BASE_DV + {4'h0, high_rail_fail_level};
            level_legal = 1'b1;
        end
        else
        begin
            // code 4 is 1.7 V, 0.1 V per step up to 2.8 V
            threshold_dv = `FAIL_LEVEL_BASE_DV + {4'h0, fail_level}
                - {4'h0, `FAIL_LEVEL_BASE_CODE};
            level_legal = (fail_level >= `FAIL_LEVEL_BASE_CODE);
        end
    end
endmodule
`default_nettype wire

// File: hdl/power_fail_regs.v
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "power_fail_defines.vh"

// Overview of operation
// - warn_enable bit turns power-fail warning on
// - normal codes 4..15 give 1.7..2.8 V
// - fail_level applies in normal supply mode only
// - high rail codes 0..15 give 2.7..4.2 V
// - high rail level used only in high mode
// - powerfail_config at 0x510, resets zero
// - two retained scratch registers, reset zero
// - buck_converter_enable register at 0x578
// - main_supply_state reports main supply state
module power_fail_regs
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // analog side
    input wire supply_below_threshold,
    input wire high_voltage_mode,
    input wire [31:0] main_supply_status_in,
    output reg warn_enable,
    output reg [3:0] fail_level,
    output reg [3:0] high_rail_fail_level,
    output reg [7:0] threshold_dv,
    output reg buck_enable,
    // interrupt
    output wire irq
);
    reg [31:0] retained_scratch_a;
    reg [31:0] retained_scratch_b;
    reg [31:0] buck_converter_enable;
    reg [31:0] main_supply_state;
    reg [1:0] irq_status;
    reg [1:0] irq_mask;
    reg ack;
    reg below_s1;
    reg below_s2;
    reg below_s3;
    reg below_state;
    reg illegal_seen;
    wire [7:0] next_threshold;
    wire level_legal;
    wire access;
    wire wr;
    wire warn_event;
    wire illegal_event;
    reg [31:0] next_rdata;

    function [31:0] byte_merge;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                byte_merge[i*8 +: 8] = sel[i] ? new_value[i*8 +: 8] : old_value[i*8 +: 8];
            end
        end
    endfunction

    threshold_select u_threshold
    (
        .fail_level(fail_level),
        .high_rail_fail_level(high_rail_fail_level),
        .high_voltage_mode(high_voltage_mode),
        .threshold_dv(next_threshold),
        .level_legal(level_legal)
    );

    assign access = wb_cyc_i && wb_stb_i && !ack;
    assign wr = access && wb_we_i && clock_enable;
    assign wb_ack_o = ack;
    assign irq = |(irq_status & irq_mask);

    // warning fires on the agreed falling edge of the supply
    assign warn_event = warn_enable && (below_s2 == below_s3) && below_s3 && !below_state;
    assign illegal_event = warn_enable && !level_legal && !high_voltage_mode && !illegal_seen;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `OFF_POWERFAIL_CONFIG:
            begin
                next_rdata[`WARN_ENABLE_BIT] = warn_enable;
                next_rdata[`FAIL_LEVEL_MSB:`FAIL_LEVEL_LSB] = fail_level;
                next_rdata[`HIGH_LEVEL_MSB:`HIGH_LEVEL_LSB] = high_rail_fail_level;
            end
            `OFF_SCRATCH_A: next_rdata = retained_scratch_a;
            `OFF_SCRATCH_B: next_rdata = retained_scratch_b;
            `OFF_BUCK_ENABLE: next_rdata = buck_converter_enable;
            `OFF_MAIN_SUPPLY: next_rdata = main_supply_state;
            `OFF_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
            `OFF_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            warn_enable <= 1'b0;
            fail_level <= 4'h0;
            high_rail_fail_level <= 4'h0;
            retained_scratch_a <= `RESET_SCRATCH;
            retained_scratch_b <= `RESET_SCRATCH;
            buck_converter_enable <= `RESET_BUCK_ENABLE;
            buck_enable <= 1'b0;
            main_supply_state <= 32'h0000_0000;
            threshold_dv <= 8'h00;
            irq_status <= 2'b00;
            irq_mask <= 2'b00;
            ack <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            below_s1 <= 1'b0;
            below_s2 <= 1'b0;
            below_s3 <= 1'b0;
            below_state <= 1'b0;
            illegal_seen <= 1'b0;
        end
        else if (clock_enable)
        begin
            ack <= access;
            below_s1 <= supply_below_threshold;
            below_s2 <= below_s1;
            below_s3 <= below_s2;
            if (below_s2 == below_s3)
            begin
                below_state <= below_s3;
            end
            main_supply_state <= main_supply_status_in;
            threshold_dv <= next_threshold;
            buck_enable <= buck_converter_enable[0];
            illegal_seen <= warn_enable && !level_legal && !high_voltage_mode;
            if (access)
            begin
                wb_dat_o <= next_rdata;
            end
            if (wr)
            begin
                case (wb_adr_i)
                    `OFF_POWERFAIL_CONFIG:
                    begin
                        if (wb_sel_i[0])
                        begin
                            warn_enable <= wb_dat_i[`WARN_ENABLE_BIT];
                            fail_level <= wb_dat_i[`FAIL_LEVEL_MSB:`FAIL_LEVEL_LSB];
                        end
                        if (wb_sel_i[1])
                        begin
                            high_rail_fail_level <= wb_dat_i[`HIGH_LEVEL_MSB:`HIGH_LEVEL_LSB];
                        end
                    end
                    `OFF_SCRATCH_A:
                        retained_scratch_a <= byte_merge(retained_scratch_a, wb_dat_i, wb_sel_i);
                    `OFF_SCRATCH_B:
                        retained_scratch_b <= byte_merge(retained_scratch_b, wb_dat_i, wb_sel_i);
                    `OFF_BUCK_ENABLE:
                        buck_converter_enable <= byte_merge(buck_converter_enable, wb_dat_i,
                            wb_sel_i);
                    `OFF_IRQ_MASK:
                        if (wb_sel_i[0])
                        begin
                            irq_mask <= wb_dat_i[1:0];
                        end
                    default:
                    begin
                    end
                endcase
            end
            // set wins over write-one-to-clear
            irq_status[0] <= warn_event |
                (irq_status[0] & ~(wr && wb_adr_i == `OFF_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[0]));
            irq_status[1] <= illegal_event |
                (irq_status[1] & ~(wr && wb_adr_i == `OFF_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[1]));
        end
    end
endmodule
`default_nettype wire

// File: dv/power_fail_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module power_fail_regs_sva
(
    // watched ports
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire high_voltage_mode,
    input wire warn_enable,
    input wire [3:0] fail_level,
    input wire [3:0] high_rail_fail_level,
    input wire [7:0] threshold_dv,
    input wire buck_enable
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire req = clock_enable & wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire cfg = req & wb_we_i & (wb_adr_i == 12'h0510);
    AST_ACK_NEXT: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_PULSE: assert property (wb_ack_o && clock_enable |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_WARN_BIT: assert property (cfg && wb_sel_i[0] |=> warn_enable == $past(wb_dat_i[0]))
        else $error("warn enable not written");
    AST_FAIL_FIELD: assert property (cfg && wb_sel_i[0] |=> fail_level == $past(wb_dat_i[4:1]))
        else $error("fail level not written");
    AST_HIGH_FIELD: assert property (cfg && wb_sel_i[1]
        |=> high_rail_fail_level == $past(wb_dat_i[11:8]))
        else $error("high rail level not written");
    AST_THR_NORMAL: assert property (clock_enable && !high_voltage_mode && fail_level > 4'h3
        |=> threshold_dv == 8'h0D + $past(fail_level))
        else $error("normal threshold wrong");
    AST_THR_HIGH: assert property (clock_enable && high_voltage_mode
        |=> threshold_dv == 8'h1B + $past(high_rail_fail_level))
        else $error("high mode threshold wrong");
    AST_BUCK: assert property (req && wb_we_i && wb_adr_i == 12'h0578 && wb_sel_i[0]
        |=> ##1 buck_enable == $past(wb_dat_i[0], 2))
        else $error("buck enable not mirrored");
    AST_RESET_ZERO: assert property (disable iff (1'b0) !rst_n && clock_enable
        |=> !warn_enable && fail_level == 4'h0 && high_rail_fail_level == 4'h0)
        else $error("config not cleared by reset");
    cover property (cfg);
    cover property (high_voltage_mode && fail_level > 4'h3);
    cover property ($rose(buck_enable));
endmodule
`default_nettype wire

// File: dv/test_power_fail_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_power_fail_regs;
    logic clock = '0, rst_n = '0, clock_enable = 1'b1;
    logic wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o, irq;
    logic supply_below_threshold = '0, high_voltage_mode = '0, warn_enable, buck_enable;
    logic [11:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0, fail_level, high_rail_fail_level, s;
    logic [7:0] threshold_dv;
    logic [31:0] wb_dat_i = '0, wb_dat_o, main_supply_status_in = '0, rd, v;
    logic [31:0] sm [2] = '{32'h0, 32'h0};
    logic [11:0] regs [4] = '{12'h0510, 12'h051C, 12'h0520, 12'h0578};
    int err_total = 0, total_checks = 0, ticks = 0, j;
    power_fail_regs DUT (.*);
    always #25 clock = ~clock;
    always @(posedge clock) if (++ticks > 20000) begin err_total++; close_out; end
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
        for (int i = 0; i < 4; i++) if (m[i]) o[8*i+:8] = n[8*i+:8];
        return o;
    endfunction
    task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= m;
        wb_dat_i <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // supply dips below threshold after a quiet spell
    task automatic dip;
        supply_below_threshold <= 1'b0;
        repeat (6) @(posedge clock);
        supply_below_threshold <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h0b3e_ff68));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        foreach (regs[i]) begin wb(0, regs[i], 4'hF, '0); `CHK(rd, 32'h0) end
        wb(0, 12'h07F0, 4'hF, '0); `CHK(rd, 32'h0)
        repeat (20) begin
            j = $urandom_range(1);
            v = $urandom;
            s = $urandom;
            sm[j] = merge(sm[j], v, s);
            wb(1, j ? 12'h0520 : 12'h051C, s, v);
            wb(0, j ? 12'h0520 : 12'h051C, 4'hF, '0); `CHK(rd, sm[j])
        end
        for (int c = 4; c < 16; c++) begin
            v = $urandom;
            v[4:1] = c;
            wb(1, 12'h0510, 4'hF, v);
            wb(0, 12'h0510, 4'hF, '0); `CHK(rd, v & 32'h0000_0F1F)
            repeat (3) @(posedge clock); `CHK(threshold_dv, 8'(c + 13))
            high_voltage_mode <= 1'b1;
            repeat (3) @(posedge clock); `CHK(threshold_dv, 8'(v[11:8] + 27))
            high_voltage_mode <= 1'b0;
        end
        wb(1, 12'h0578, 4'h1, 32'h1);
        repeat (2) @(posedge clock); `CHK(buck_enable, 1'b1)
        v = $urandom;
        main_supply_status_in <= v;
        wb(1, 12'h0640, 4'hF, ~v);
        wb(0, 12'h0640, 4'hF, '0); `CHK(rd, v)
        wb(1, 12'h0704, 4'hF, 32'h1);
        wb(1, 12'h0510, 4'hF, 32'h9);
        wb(1, 12'h0700, 4'hF, 32'h3);
        dip; `CHK(irq, 1'b1)
        wb(1, 12'h0700, 4'hF, 32'h1);
        @(posedge clock); `CHK(irq, 1'b0)
        wb(1, 12'h0704, 4'hF, 32'h0);
        dip; `CHK(irq, 1'b0)
        wb(0, 12'h0700, 4'hF, '0); `CHK(rd[0], 1'b1)
        wb(1, 12'h0700, 4'hF, 32'h1);
        wb(1, 12'h0704, 4'hF, 32'h1);
        wb(1, 12'h0510, 4'hF, 32'h8);
        dip; `CHK(irq, 1'b0)
        // enabled warning with a too-low level flags status bit 1
        wb(1, 12'h0700, 4'hF, 32'h3);
        wb(1, 12'h0510, 4'hF, 32'h1);
        repeat (2) @(posedge clock);
        wb(0, 12'h0700, 4'hF, '0); `CHK(rd[1], 1'b1)
        // low clock enable freezes the selected threshold
        clock_enable <= 1'b0;
        high_voltage_mode <= 1'b1;
        repeat (3) @(posedge clock); `CHK(threshold_dv, 8'h0D)
        clock_enable <= 1'b1;
        repeat (3) @(posedge clock); `CHK(threshold_dv, 8'h1B)
        high_voltage_mode <= 1'b0;
        close_out;
    end
endmodule
bind power_fail_regs power_fail_regs_sva chk (.*);
`default_nettype wire
